// File: rtl/sbd_core.sv
/*
  execute stage for decrement_skip_on_zero, increment_skip_on_zero and
  unconditional_jump: computes results, write-back, skip and pc load.
  assumes the core supplies the file register value for the addressed
  operand combinationally, applies write-back at the next edge, and
  fetches from pc_out; other instructions are handled elsewhere.
  a word presented while busy_out is high is the discarded prefetch and
  is ignored, so the core presents the next real word one cycle later.
  reset is synchronous and clears every registered output.
*/
// Function
// RQ1: opcode 00 1011 d fffffff decrements the operand and flags a skip when the result is zero.
// RQ2: opcode 00 1111 d fffffff increments the operand modulo 256 and skips when it wraps to zero.
// RQ3: the 7-bit field selects register 0..127 and d=0 writes the accumulator, d=1 the register.
// RQ4: a zero skip result discards the prefetched word and runs a nop, taking two cycles.
// RQ5: opcode 10 1 kkkkkkkkkkk is the jump and loads the immediate into pc bits 10:0.
// RQ6: the jump fills pc bits 12:11 from bits 4:3 of the pc high latch.
// RQ7: the jump always takes two cycles, the second flushing the prefetch.
// RQ8: none of these instructions touch the zero, carry or digit-carry flags.
`timescale 1ns/1ps
module sbd_core (
  // clock and reset
  input  wire logic                        mclk_in,
  input  wire logic                        srst_in,
  // instruction issue
  input  wire logic                        insn_valid_in,
  input  wire logic [sbd_pkg::INSN_W-1:0]  insn_in,
  input  wire logic [sbd_pkg::PC_W-1:0]    pc_in,
  // operands
  input  wire logic [sbd_pkg::DATA_W-1:0]  file_rdata_in,
  input  wire logic [sbd_pkg::DATA_W-1:0]  pc_high_latch_in,
  // write-back
  output sbd_pkg::sbd_wb_t                 wb_out,
  output logic [sbd_pkg::FADDR_W-1:0]      file_raddr_out,
  // sequencing
  output logic                             busy_out,
  output logic                             flush_out,
  output logic                             pc_load_out,
  output logic [sbd_pkg::PC_W-1:0]         pc_out,
  output logic                             status_we_out
);
  typedef enum logic {
    SBD_EXEC,
    SBD_FLUSH
  } sbd_state_t;

  sbd_pkg::sbd_dec_t               dec;
  sbd_state_t                      state_ff;
  sbd_state_t                      nxt_state;
  logic [sbd_pkg::DATA_W-1:0]      result;
  logic                            is_skip_op;
  logic                            take;
  logic                            skip;
  sbd_pkg::sbd_wb_t                wb_ff;
  logic                            flush_ff;
  logic                            pc_load_ff;
  logic [sbd_pkg::PC_W-1:0]        pc_ff;
  logic                            is_dec;
  logic                            is_inc;
  logic                            is_jump;
  logic                            jump_take;
  logic                            to_file;
  logic [sbd_pkg::PC_W-1:0]        jump_target;
  logic [sbd_pkg::PC_W-1:0]        skip_target;
  sbd_pkg::sbd_wb_t                nxt_wb;
  logic                            nxt_flush;
  logic                            nxt_pc_load;
  logic [sbd_pkg::PC_W-1:0]        nxt_pc;

  // refuse package constants that the field split cannot serve
  if (sbd_pkg::PC_W !=
      sbd_pkg::JUMP_W + sbd_pkg::LATCH_HI - sbd_pkg::LATCH_LO + 1) begin : g_chk_pc_w
    $error("pc width must be the jump field plus the latch bits");
  end
  if (sbd_pkg::JUMP_HI + 1 != sbd_pkg::JUMP_W) begin : g_chk_jump_w
    $error("jump field top bit does not match its width");
  end
  if (sbd_pkg::FADDR_HI + 1 != sbd_pkg::FADDR_W) begin : g_chk_faddr_w
    $error("file field top bit does not match its width");
  end
  if (sbd_pkg::DEST_BIT != sbd_pkg::FADDR_W) begin : g_chk_dest
    $error("destination bit must sit just above the file field");
  end
  if (sbd_pkg::OP6_HI != sbd_pkg::INSN_W - 1 ||
      sbd_pkg::OP6_HI - sbd_pkg::OP6_LO + 1 != $bits(sbd_pkg::OP_DEC_SKIP)) begin : g_chk_op6
    $error("skip opcode field does not fit the word top");
  end
  if (sbd_pkg::OP3_HI != sbd_pkg::INSN_W - 1 ||
      sbd_pkg::OP3_HI - sbd_pkg::OP3_LO + 1 != $bits(sbd_pkg::OP_JUMP)) begin : g_chk_op3
    $error("jump opcode field does not fit the word top");
  end
  if (sbd_pkg::JUMP_HI >= sbd_pkg::OP3_LO) begin : g_chk_overlap
    $error("jump immediate overlaps its opcode");
  end
  if (sbd_pkg::DEST_BIT >= sbd_pkg::OP6_LO) begin : g_chk_dest_op
    $error("destination bit overlaps the skip opcode");
  end
  if (sbd_pkg::LATCH_HI >= sbd_pkg::DATA_W ||
      sbd_pkg::LATCH_LO > sbd_pkg::LATCH_HI) begin : g_chk_latch
    $error("latch bits fall outside the latch register");
  end

  sbd_decode u_decode (
    .insn_in (insn_in),
    .dec_out (dec)
  );

  // operand read address follows the file field
  assign file_raddr_out = dec.faddr; // RQ3

  // instruction is accepted only in the execute state
  assign take       = insn_valid_in && (state_ff == SBD_EXEC);

  // opcode kinds and destination of the word on insn_in
  assign is_dec     = (dec.op == sbd_pkg::SBD_OP_DEC_SKIP);
  assign is_inc     = (dec.op == sbd_pkg::SBD_OP_INC_SKIP);
  assign is_jump    = (dec.op == sbd_pkg::SBD_OP_JUMP);
  assign is_skip_op = is_dec || is_inc;
  assign jump_take  = take && is_jump;
  assign to_file    = (dec.dest == sbd_pkg::SBD_DEST_FILE);

  // arithmetic, wrapping at the data width
  always_comb begin
    case (dec.op)
      sbd_pkg::SBD_OP_DEC_SKIP: result = file_rdata_in - sbd_pkg::ONE; // RQ1
      sbd_pkg::SBD_OP_INC_SKIP: result = file_rdata_in + sbd_pkg::ONE; // RQ2
      default:                  result = file_rdata_in;
    endcase
  end

  // skip when a skip-on-zero result is zero
  assign skip = take && is_skip_op && (result == sbd_pkg::ZERO); // RQ1 RQ2

  // second cycle after a taken skip or a jump
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SBD_EXEC: begin
        if (skip || jump_take) begin
          nxt_state = SBD_FLUSH; // RQ4 RQ7
        end
      end
      SBD_FLUSH: nxt_state = SBD_EXEC;
      default:   nxt_state = SBD_EXEC;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      state_ff <= SBD_EXEC;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // jump target: latch bits on top of the immediate
  assign jump_target = {pc_high_latch_in[sbd_pkg::LATCH_HI:sbd_pkg::LATCH_LO], // RQ6
                        dec.target};                                            // RQ5

  // skip target lands past the discarded word
  assign skip_target = pc_in + sbd_pkg::SKIP_STEP; // RQ4

  // write-back of a taken skip-on-zero result
  always_comb begin
    nxt_wb         = '0;
    nxt_wb.acc_we  = take && is_skip_op && !to_file; // RQ3
    nxt_wb.file_we = take && is_skip_op && to_file;  // RQ3
    nxt_wb.faddr   = dec.faddr;
    nxt_wb.data    = result;
  end

  // flush marks the slot whose prefetched word is discarded
  assign nxt_flush = (state_ff == SBD_EXEC) && (nxt_state == SBD_FLUSH); // RQ4 RQ7

  // pc load: jump target, or skip past the discarded word
  always_comb begin
    nxt_pc_load = 1'b0;
    nxt_pc      = pc_ff;
    if (jump_take) begin
      nxt_pc_load = 1'b1;
      nxt_pc      = jump_target; // RQ5 RQ6
    end else if (skip) begin
      nxt_pc_load = 1'b1;
      nxt_pc      = skip_target; // RQ4
    end
  end

  // write-back register, enables are one-cycle pulses
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      wb_ff <= '0;
    end else begin
      wb_ff <= nxt_wb;
    end
  end

  // flush pulse register
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      flush_ff <= 1'b0;
    end else begin
      flush_ff <= nxt_flush;
    end
  end

  // pc load pulse; the target holds until the next load
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      pc_load_ff <= 1'b0;
      pc_ff      <= '0;
    end else begin
      pc_load_ff <= nxt_pc_load;
      pc_ff      <= nxt_pc;
    end
  end

  assign wb_out        = wb_ff;
  assign flush_out     = flush_ff;
  assign pc_load_out   = pc_load_ff;
  assign pc_out        = pc_ff;
  assign busy_out      = (state_ff == SBD_FLUSH);
  assign status_we_out = 1'b0; // RQ8
endmodule

// File: rtl/sbd_pkg.sv
/*
  package for the skip and branch decoder: opcode patterns, field
  positions, widths and the decoded-instruction and write-back types.
  assumes a 14-bit instruction word, 8-bit data and a 13-bit program counter.
*/
package sbd_pkg;
  localparam int INSN_W      = 14;
  localparam int DATA_W      = 8;
  localparam int PC_W        = 13;
  localparam int FADDR_W     = 7;
  localparam int JUMP_W      = 11;
  // skip-on-zero opcode sits in bits 13:8
  localparam int OP6_HI      = 13;
  localparam int OP6_LO      = 8;
  localparam logic [5:0] OP_DEC_SKIP = 6'h0B;  // 00 1011
  localparam logic [5:0] OP_INC_SKIP = 6'h0F;  // 00 1111
  // jump opcode sits in bits 13:11
  localparam int OP3_HI      = 13;
  localparam int OP3_LO      = 11;
  localparam logic [2:0] OP_JUMP     = 3'h5;   // 10 1
  localparam int DEST_BIT    = 7;
  localparam int FADDR_HI    = 6;
  localparam int JUMP_HI     = 10;
  // pc high latch bits that feed pc 12:11
  localparam int LATCH_HI    = 4;
  localparam int LATCH_LO    = 3;
  localparam logic [DATA_W-1:0] ONE  = 8'h01;
  localparam logic [DATA_W-1:0] ZERO = 8'h00;
  // a taken skip moves the pc past the discarded word
  localparam logic [PC_W-1:0]   SKIP_STEP = 13'h0002;

  typedef enum logic {
    SBD_DEST_ACC,
    SBD_DEST_FILE
  } sbd_dest_t;

  typedef enum logic [1:0] {
    SBD_OP_NONE,
    SBD_OP_DEC_SKIP,
    SBD_OP_INC_SKIP,
    SBD_OP_JUMP
  } sbd_op_t;

  // decoded instruction
  typedef struct packed {
    sbd_op_t              op;
    logic                 dest;
    logic [FADDR_W-1:0]   faddr;
    logic [JUMP_W-1:0]    target;
  } sbd_dec_t;

  // write-back of a result
  typedef struct packed {
    logic                 acc_we;
    logic                 file_we;
    logic [FADDR_W-1:0]   faddr;
    logic [DATA_W-1:0]    data;
  } sbd_wb_t;
endpackage

// File: rtl/sbd_decode.sv
/*
  combinational opcode decoder for the skip-on-zero and jump instructions.
  assumes the instruction word is stable for the whole execute cycle.
*/
`timescale 1ns/1ps
module sbd_decode (
  // instruction in
  input  wire logic [sbd_pkg::INSN_W-1:0] insn_in,
  // decoded fields out
  output sbd_pkg::sbd_dec_t               dec_out
);
  // opcode match and field split
  always_comb begin
    dec_out        = '0;
    dec_out.op     = sbd_pkg::SBD_OP_NONE;
    dec_out.dest   = insn_in[sbd_pkg::DEST_BIT];
    dec_out.faddr  = insn_in[sbd_pkg::FADDR_HI:0];
    dec_out.target = insn_in[sbd_pkg::JUMP_HI:0];
    if (insn_in[sbd_pkg::OP6_HI:sbd_pkg::OP6_LO] == sbd_pkg::OP_DEC_SKIP) begin
      dec_out.op = sbd_pkg::SBD_OP_DEC_SKIP; // RQ1
    end else if (insn_in[sbd_pkg::OP6_HI:sbd_pkg::OP6_LO] == sbd_pkg::OP_INC_SKIP) begin
      dec_out.op = sbd_pkg::SBD_OP_INC_SKIP; // RQ2
    end else if (insn_in[sbd_pkg::OP3_HI:sbd_pkg::OP3_LO] == sbd_pkg::OP_JUMP) begin
      dec_out.op = sbd_pkg::SBD_OP_JUMP; // RQ5
    end
  end
endmodule

// File: tb/sbd_core_asserts.sv
/* assertions for the skip and jump execute stage.
   assumes it is bound to sbd_core and sees only its ports. */
`timescale 1ns/1ps
module sbd_core_asserts (
  // watched ports
  input wire logic        mclk_in,
  input wire logic        srst_in,
  input wire logic        insn_valid_in,
  input wire logic [13:0] insn_in,
  input wire logic [7:0]  file_rdata_in,
  input wire logic [7:0]  pc_high_latch_in,
  input sbd_pkg::sbd_wb_t wb_out,
  input wire logic [6:0]  file_raddr_out,
  input wire logic        busy_out,
  input wire logic        flush_out,
  input wire logic        pc_load_out,
  input wire logic [12:0] pc_out,
  input wire logic        status_we_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  // taken words by kind
  wire logic tk = insn_valid_in && !busy_out;
  wire logic dk = tk && insn_in[13:8] == 6'h0B;
  wire logic ik = tk && insn_in[13:8] == 6'h0F;
  wire logic jp = tk && insn_in[13:11] == 3'h5;
  sequence s_flush_slot;
    busy_out && flush_out && pc_load_out ##1 !busy_out;
  endsequence
  sequence s_zero_res;
    (dk || ik) ##1 wb_out.data == 8'h00;
  endsequence
  a_dec_result: assert property (dk |=> wb_out.data == $past(file_rdata_in) - 8'h01)
    else $error("bad decrement");
  a_inc_result: assert property (ik |=> wb_out.data == $past(file_rdata_in) + 8'h01)
    else $error("bad increment");
  a_dest_sel: assert property ((dk || ik) |=> wb_out.file_we == $past(insn_in[7])
    && wb_out.acc_we != $past(insn_in[7]) && wb_out.faddr == $past(insn_in[6:0]))
    else $error("bad destination");
  a_read_addr: assert property (file_raddr_out == insn_in[6:0])
    else $error("bad read address");
  a_zero_skip: assert property (s_zero_res |-> s_flush_slot)
    else $error("no skip on zero");
  a_nonzero_one: assert property ((dk || ik) |=> wb_out.data != 8'h00 |-> !busy_out)
    else $error("skip on nonzero");
  a_jump_target: assert property (jp |=> pc_out == {$past(pc_high_latch_in[4:3]),
    $past(insn_in[10:0])}) else $error("bad jump target");
  a_jump_two: assert property (jp |=> s_flush_slot)
    else $error("jump not two cycles");
  a_flags_quiet: assert property (!status_we_out)
    else $error("flag write seen");
endmodule
bind sbd_core sbd_core_asserts u_chk (.mclk_in(mclk_in), .srst_in(srst_in),
  .insn_valid_in(insn_valid_in), .insn_in(insn_in), .file_rdata_in(file_rdata_in),
  .pc_high_latch_in(pc_high_latch_in), .wb_out(wb_out), .file_raddr_out(file_raddr_out),
  .busy_out(busy_out), .flush_out(flush_out), .pc_load_out(pc_load_out),
  .pc_out(pc_out), .status_we_out(status_we_out));

// File: tb/tb.sv
/* self-checking bench for sbd_core with random words.
   assumes the package and design files are compiled first. */
`timescale 1ns/1ps
module tb;
  logic             mclk_in, srst_in, insn_valid_in, held;
  logic             busy_out, flush_out, pc_load_out, status_we_out;
  logic [13:0]      insn_in;
  logic [12:0]      pc_in, pc_out, pc_q[$];
  logic [7:0]       file_rdata_in, pc_high_latch_in, res;
  logic [6:0]       file_raddr_out;
  sbd_pkg::sbd_wb_t wb_out, wb_q[$];
  logic [31:0]      rnd;
  int               bad_count, total_checks, cyc;
  sbd_core dut (.mclk_in(mclk_in), .srst_in(srst_in), .insn_valid_in(insn_valid_in),
    .insn_in(insn_in), .pc_in(pc_in), .file_rdata_in(file_rdata_in),
    .pc_high_latch_in(pc_high_latch_in), .wb_out(wb_out), .file_raddr_out(file_raddr_out),
    .busy_out(busy_out), .flush_out(flush_out), .pc_load_out(pc_load_out),
    .pc_out(pc_out), .status_we_out(status_we_out));
  // clock
  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction
  task automatic cmp_wb(input string nm, input sbd_pkg::sbd_wb_t e, g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_pc(input string nm, input logic [12:0] e, g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run;
    if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // watcher: each result against the oldest note, plus the hang limit
  always @(negedge mclk_in) begin
    if (!srst_in && (wb_out.acc_we | wb_out.file_we) !== 1'b0)
      cmp_wb("wb_out", wb_q.size() > 0 ? wb_q.pop_front() : '1, wb_out);
    if (!srst_in && pc_load_out !== 1'b0)
      cmp_pc("pc_out", pc_q.size() > 0 ? pc_q.pop_front() : 13'h1FFF, pc_out);
    cyc = cyc + 1;
    if (cyc > 2000) begin
      bad_count++;
      complete_run();
    end
  end
  // stimulus at the falling edge, noting what each word should give
  initial begin
    {srst_in, insn_valid_in, insn_in, pc_in, file_rdata_in, pc_high_latch_in} = '0;
    srst_in = 1'b1;
    held = 1'b0;
    rnd = 32'h86E3EEBA;
    repeat (10) @(negedge mclk_in);
    srst_in = 1'b0;
    repeat (400) begin
      rnd = lfsr(rnd);
      insn_in = rnd[13:0];
      if (rnd[15:14] != 2'h3)
        insn_in[13:8] = rnd[15:14] == 2'h0 ? 6'h0B : rnd[15] ? {3'h5, rnd[10:8]} : 6'h0F;
      pc_in = rnd[28:16];
      pc_high_latch_in = rnd[31:24];
      file_rdata_in = rnd[17] ? rnd[27:20] : (insn_in[10] ? 8'hFF : 8'h01);
      insn_valid_in = rnd[19:18] != 2'h0;
      res = insn_in[10] ? file_rdata_in + 8'h01 : file_rdata_in - 8'h01;
      if (held) held = 1'b0;
      else if (insn_valid_in && (insn_in[13:8] == 6'h0B || insn_in[13:8] == 6'h0F)) begin
        wb_q.push_back({!insn_in[7], insn_in[7], insn_in[6:0], res});
        if (res == 8'h00) pc_q.push_back(pc_in + 13'h0002);
        held = res == 8'h00;
      end else if (insn_valid_in && insn_in[13:11] == 3'h5) begin
        pc_q.push_back({pc_high_latch_in[4:3], insn_in[10:0]});
        held = 1'b1;
      end
      @(negedge mclk_in);
    end
    insn_valid_in = 1'b0;
    repeat (3) @(negedge mclk_in);
    cmp_pc("pending", 13'h0000, 13'(wb_q.size() + pc_q.size()));
    complete_run();
  end
endmodule
